/* rtl/mcr_pkg.sv */
// package for the memory controller configuration register bank
// assumes a 32-bit AXI4-Lite register bus, one clock
package mcr_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [3:0] ADDR_REG_A = 4'h0;
  localparam logic [3:0] ADDR_REG_B = 4'h4;
  localparam logic [3:0] ADDR_REG_C = 4'h8;
  // ==========================================================
  // register A fields
  localparam int A_POWER_UP_STATUS   = 23;
  localparam int A_POWER_DOWN_STATUS  = 22;
  localparam int A_SIZE_LO  = 9;
  localparam int A_ILV_WE   = 8;
  localparam int A_TYPE_LO  = 3;
  localparam int A_ILV      = 0;
  // ==========================================================
  // register B fields
  localparam int B_RPTR_LO  = 30;
  localparam int B_WPTR_LO  = 28;
  localparam int B_SA_LO    = 15;
  localparam int B_SA_WE    = 14;
  localparam int B_INIT12   = 12;
  localparam int B_INIT13   = 13;
  localparam int B_FORCE    = 9;
  localparam int B_BYPASS   = 8;
  // ==========================================================
  // register C fields
  localparam int C_INH_CRD  = 30;
  localparam int C_HIGH_ERR = 29;
  localparam int C_LOG_REQ  = 28;
  localparam int C_ADDR_LO  = 8;
  // ==========================================================
  // forced check bit address bits, start address defaults (64K units)
  localparam int FORCE_ADR_BIT0 = 3;
  localparam int FORCE_ADR_BIT1 = 12;
  localparam logic [12:0] SA_4MB  = 13'h0040;
  localparam logic [12:0] SA_8MB  = 13'h0080;
  localparam logic [12:0] SA_12MB = 13'h00C0;
  localparam logic [12:0] SA_ZERO = 13'h0000;
  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;
  localparam logic [1:0]  INIT_BUSY  = 2'b00;
  localparam logic [1:0]  INIT_SAVED = 2'b01;
  localparam logic [1:0]  INIT_COLD  = 2'b11;

  // error report from the read datapath
  typedef struct packed {
    logic        valid;
    logic        correctable;
    logic [19:0] addr;
    logic [7:0]  syndrome;
  } mcr_err_t;

  // ecc controls toward the datapath
  typedef struct packed {
    logic       bypass;
    logic       force_en;
    logic [7:0] subst;
  } mcr_ecc_t;
endpackage

/* rtl/mcr_regs.sv */
// memory controller configuration and status registers over AXI4-Lite
// assumes the datapath, jumpers and power signals are outside this block
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module mcr_regs #(
  parameter int SIZE_W = 7
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              cold_start,
  input  wire logic              ac_low,
  input  wire logic              inhibit_rom_decode,
  input  wire logic              start_jumper_high,
  input  wire logic              start_jumper_low,
  input  wire logic [SIZE_W-1:0] mem_size,
  input  wire logic [1:0]        mem_type,
  input  wire logic [1:0]        file_rd_ptr,
  input  wire logic [1:0]        file_wr_ptr,
  input  wire logic              init_active,
  input  wire logic              init_done,
  input  wire logic              array_cmd,
  input  wire logic [31:0]       rd_addr,
  input  wire mcr_pkg::mcr_err_t err_in,
  output logic                   power_alert_line,
  output logic                   array_busy,
  output logic                   force_check_bits,
  output mcr_pkg::mcr_ecc_t      ecc_ctrl,
  output logic                   corrected_read_flag,
  output logic                   read_data_substitute_flag,
  output logic                   interleave_bits,
  output logic [12:0]            start_addr,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] ac_sync_reg;
  logic [1:0] cold_sync_reg;
  logic       ac_seen_reg;
  // straps are static in use but still arrive from pins
  logic [2:0] strap_s1_reg;
  logic [2:0] strap_s2_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ac_sync_reg   <= 2'b00;
      cold_sync_reg <= 2'b00;
      ac_seen_reg   <= 1'b0;
      strap_s1_reg  <= 3'b000;
      strap_s2_reg  <= 3'b000;
    end else begin
      ac_sync_reg   <= {ac_sync_reg[0], ac_low};
      cold_sync_reg <= {cold_sync_reg[0], cold_start};
      ac_seen_reg   <= ac_sync_reg[1];
      strap_s1_reg  <= {inhibit_rom_decode, start_jumper_high,
                        start_jumper_low};
      strap_s2_reg  <= strap_s1_reg;
    end
  end
  wire logic ac_rise = ac_sync_reg[1] & ~ac_seen_reg;
  wire logic ac_fall = ~ac_sync_reg[1] & ac_seen_reg;
  wire logic cold    = cold_sync_reg[1];
  wire logic rom_inh = strap_s2_reg[2];

  // ==========================================================
  // AXI4-Lite write side: address and data taken in either order
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take  = s_axi_wvalid & s_axi_wready;
  wire logic wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mcr_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_reg & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(aw_addr_reg) ? mcr_pkg::AXI_OKAY
                                             : mcr_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == mcr_pkg::ADDR_REG_A) || (a == mcr_pkg::ADDR_REG_B) ||
              (a == mcr_pkg::ADDR_REG_C);
  endfunction

  // a write counts only when all four byte lanes are enabled
  wire logic full_wr = wr_fire & (w_strb_reg == 4'hF);
  wire logic wr_a = full_wr & (aw_addr_reg == mcr_pkg::ADDR_REG_A);
  wire logic wr_b = full_wr & (aw_addr_reg == mcr_pkg::ADDR_REG_B);
  wire logic wr_c = full_wr & (aw_addr_reg == mcr_pkg::ADDR_REG_C);
  wire logic [31:0] wd = w_data_reg;

  // ==========================================================
  // power status and alert
  logic power_up_status_reg;
  logic power_down_status_reg;
  wire logic clr_up  = wr_a & wd[mcr_pkg::A_POWER_UP_STATUS] & power_up_status_reg;
  wire logic clr_dwn = wr_a & wd[mcr_pkg::A_POWER_DOWN_STATUS] & power_down_status_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_up_status_reg       <= 1'b0;
      power_down_status_reg      <= 1'b0;
      power_alert_line <= 1'b0;
    end else if (ac_rise && rom_inh) begin
      power_down_status_reg      <= 1'b1;
      power_up_status_reg       <= 1'b0;
      power_alert_line <= 1'b1;
    end else if (ac_fall) begin
      power_up_status_reg       <= 1'b1;
      power_down_status_reg      <= 1'b0;
      power_alert_line <= 1'b1;
    end else if (clr_up || clr_dwn) begin
      // event edges above win over a software clear
      power_up_status_reg       <= power_up_status_reg & ~clr_up;
      power_down_status_reg      <= power_down_status_reg & ~clr_dwn;
      power_alert_line <= 1'b0;
    end
  end

  // ==========================================================
  // interleave and start address; rst_n clears them to zero, and cold
  // start reloads them (interleave off, start address from the jumpers)
  logic [12:0] sa_default;
  always_comb begin
    case (strap_s2_reg[1:0])
      2'b11:   sa_default = mcr_pkg::SA_4MB;
      2'b10:   sa_default = mcr_pkg::SA_8MB;
      2'b01:   sa_default = mcr_pkg::SA_12MB;
      default: sa_default = mcr_pkg::SA_ZERO;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      interleave_bits <= 1'b0;
      start_addr      <= mcr_pkg::SA_ZERO;
    end else if (cold) begin
      interleave_bits <= 1'b0;
      start_addr      <= sa_default;
    end else begin
      if (wr_a && wd[mcr_pkg::A_ILV_WE])
        interleave_bits <= wd[mcr_pkg::A_ILV];
      if (wr_b && wd[mcr_pkg::B_SA_WE])
        start_addr <= wd[mcr_pkg::B_SA_LO +: 13];
    end
  end

  // ==========================================================
  // init status, ecc diagnostics
  logic [1:0] init_st_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_st_reg <= mcr_pkg::INIT_BUSY;
      array_busy  <= 1'b0;
    end else begin
      if (init_active)
        init_st_reg <= mcr_pkg::INIT_BUSY;
      else if (init_done)
        init_st_reg <= cold ? mcr_pkg::INIT_COLD : mcr_pkg::INIT_SAVED;
      array_busy <= init_active & array_cmd;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ecc_ctrl <= '0;
    end else if (wr_b) begin
      ecc_ctrl.force_en <= wd[mcr_pkg::B_FORCE];
      ecc_ctrl.bypass   <= wd[mcr_pkg::B_BYPASS];
      ecc_ctrl.subst    <= wd[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      force_check_bits <= 1'b0;
    else
      force_check_bits <= ecc_ctrl.force_en &
                          rd_addr[mcr_pkg::FORCE_ADR_BIT0] &
                          rd_addr[mcr_pkg::FORCE_ADR_BIT1];
  end

  // ==========================================================
  // error log
  logic        inh_crd_reg;
  logic        high_err_reg;
  logic        log_req_reg;
  logic [19:0] err_addr_reg;
  logic [7:0]  err_syn_reg;
  wire logic clr_log = wr_c & wd[mcr_pkg::C_LOG_REQ];
  wire logic first_err = err_in.valid & ~log_req_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inh_crd_reg  <= 1'b0;
      high_err_reg <= 1'b0;
      log_req_reg  <= 1'b0;
      err_addr_reg <= 20'h0_0000;
      err_syn_reg  <= 8'h00;
    end else begin
      if (wr_c)
        inh_crd_reg <= wd[mcr_pkg::C_INH_CRD];
      if (err_in.valid && log_req_reg)
        high_err_reg <= 1'b1;
      else if (wr_c && wd[mcr_pkg::C_HIGH_ERR])
        high_err_reg <= 1'b0;
      if (err_in.valid)
        log_req_reg <= 1'b1;
      else if (clr_log)
        log_req_reg <= 1'b0;
      if (first_err) begin
        err_addr_reg <= err_in.addr;
        err_syn_reg  <= err_in.syndrome;
      end
    end
  end

  // flags toward the commander with the read data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      corrected_read_flag       <= 1'b0;
      read_data_substitute_flag <= 1'b0;
    end else begin
      corrected_read_flag <= err_in.valid & err_in.correctable &
                             ~ecc_ctrl.bypass & ~inh_crd_reg &
                             ~log_req_reg;
      read_data_substitute_flag <= err_in.valid & ~err_in.correctable &
                                   ~ecc_ctrl.bypass;
    end
  end

  // ==========================================================
  // read side
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      mcr_pkg::ADDR_REG_A: begin
        rd_mux[mcr_pkg::A_POWER_UP_STATUS]  = power_up_status_reg;
        rd_mux[mcr_pkg::A_POWER_DOWN_STATUS] = power_down_status_reg;
        rd_mux[mcr_pkg::A_SIZE_LO +: SIZE_W] = mem_size;
        rd_mux[mcr_pkg::A_TYPE_LO +: 2] = mem_type;
        rd_mux[mcr_pkg::A_ILV] = interleave_bits;
      end
      mcr_pkg::ADDR_REG_B: begin
        rd_mux[mcr_pkg::B_RPTR_LO +: 2] = file_rd_ptr;
        rd_mux[mcr_pkg::B_WPTR_LO +: 2] = file_wr_ptr;
        rd_mux[mcr_pkg::B_SA_LO +: 13]  = start_addr;
        rd_mux[mcr_pkg::B_INIT12] = init_st_reg[0];
        rd_mux[mcr_pkg::B_INIT13] = init_st_reg[1];
        rd_mux[mcr_pkg::B_FORCE]  = ecc_ctrl.force_en;
        rd_mux[mcr_pkg::B_BYPASS] = ecc_ctrl.bypass;
        rd_mux[7:0] = ecc_ctrl.subst;
      end
      mcr_pkg::ADDR_REG_C: begin
        rd_mux[mcr_pkg::C_INH_CRD]  = inh_crd_reg;
        rd_mux[mcr_pkg::C_HIGH_ERR] = high_err_reg;
        rd_mux[mcr_pkg::C_LOG_REQ]  = log_req_reg;
        rd_mux[mcr_pkg::C_ADDR_LO +: 20] = err_addr_reg;
        rd_mux[7:0] = err_syn_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= mcr_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= addr_ok(s_axi_araddr) ? mcr_pkg::AXI_OKAY
                                              : mcr_pkg::AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  a_power_down_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ac_rise && rom_inh |=> power_down_status_reg && !power_up_status_reg
    && power_alert_line) else $error("power down not set");
  a_power_up_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ac_fall |=> power_up_status_reg && !power_down_status_reg && power_alert_line)
    else $error("power up not set");
  a_power_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clr_up && !ac_rise && !ac_fall |=> !power_up_status_reg && !power_alert_line)
    else $error("power clear failed");
  a_ilv_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cold && !(wr_a && wd[mcr_pkg::A_ILV_WE]) |=> $stable(interleave_bits))
    else $error("interleave changed without enable");
  a_sa_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cold && !(wr_b && wd[mcr_pkg::B_SA_WE]) |=> $stable(start_addr))
    else $error("start address changed without enable");
  a_busy_init: assert property (@(posedge clk_sys) disable iff (!rst_n)
    init_active && array_cmd |=> array_busy)
    else $error("no busy during init");
  a_crd_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    log_req_reg || inh_crd_reg || ecc_ctrl.bypass |=> !corrected_read_flag)
    else $error("corrected flag not suppressed");
  sequence s_first_err;
    err_in.valid && !log_req_reg;
  endsequence
  a_log_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_first_err ##1 !clr_log [*2] |=> log_req_reg
    && err_syn_reg == $past(err_in.syndrome, 3))
    else $error("first error not held");
  a_high_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    err_in.valid && log_req_reg |=> high_err_reg)
    else $error("high error rate not set");
endmodule
`default_nettype wire

/* sim/mcr_err_src.sv */
// stand-in for the read datapath that reports erroneous reads
// assumes one-cycle fire requests from the bench, same clock as the block
`timescale 1ns/1ns
`default_nettype none
module mcr_err_src (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              fire,
  input  wire logic              corr,
  input  wire logic [19:0]       addr,
  input  wire logic [7:0]        syn,
  output var  mcr_pkg::mcr_err_t err_in
);
  // ==========================================================
  // report pulse
  // idle payload is scrambled so the block cannot lean on stale values
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_in <= '0;
    end else if (fire) begin
      err_in <= {1'b1, corr, addr, syn};
    end else begin
      err_in <= {1'b0, ~err_in.correctable, ~err_in.addr, ~err_in.syndrome};
    end
  end
endmodule
`default_nettype wire

/* sim/mcr_regs_bench.sv */
// self-checking bench for the configuration register bank
// assumes mcr_err_src as read datapath, 250 MHz clock, AXI4-Lite master
`timescale 1ns/1ns
`default_nettype none
module mcr_regs_bench;
  // ==========================================================
  // signals
  logic clk_sys = 1'b0, rst_n = 1'b0, cold_start = 1'b1, ac_low = 1'b0;
  logic inhibit_rom_decode = 1'b1, start_jumper_high = 1'b1;
  logic start_jumper_low = 1'b0, init_active = 1'b1, init_done = 1'b0;
  logic array_cmd = 1'b0, fire = 1'b0, corr = 1'b0;
  logic [6:0]  mem_size = 7'h05;
  logic [1:0]  mem_type = 2'b10, file_rd_ptr = 2'b10, file_wr_ptr = 2'b01;
  logic [31:0] rd_addr = '0, s_axi_wdata = '0;
  logic [19:0] eaddr = '0;
  logic [7:0]  esyn = '0;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic power_alert_line, array_busy, force_check_bits, interleave_bits;
  logic corrected_read_flag, read_data_substitute_flag;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp;
  logic [31:0] s_axi_rdata, rdat;
  logic [12:0] start_addr;
  logic [12:0] sa_tab [4] = '{13'h0000, 13'h00C0, 13'h0080, 13'h0040};
  mcr_pkg::mcr_err_t err_in;
  mcr_pkg::mcr_ecc_t ecc_ctrl;
  int num_errors = 0, n_compared = 0, crd_cnt = 0, rds_cnt = 0, j;

  mcr_regs dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cold_start(cold_start),
    .ac_low(ac_low), .inhibit_rom_decode(inhibit_rom_decode),
    .start_jumper_high(start_jumper_high),
    .start_jumper_low(start_jumper_low), .mem_size(mem_size),
    .mem_type(mem_type), .file_rd_ptr(file_rd_ptr),
    .file_wr_ptr(file_wr_ptr), .init_active(init_active),
    .init_done(init_done), .array_cmd(array_cmd), .rd_addr(rd_addr),
    .err_in(err_in), .power_alert_line(power_alert_line),
    .array_busy(array_busy), .force_check_bits(force_check_bits),
    .ecc_ctrl(ecc_ctrl), .corrected_read_flag(corrected_read_flag),
    .read_data_substitute_flag(read_data_substitute_flag),
    .interleave_bits(interleave_bits), .start_addr(start_addr),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  mcr_err_src src (
    .clk_sys(clk_sys), .rst_n(rst_n), .fire(fire), .corr(corr),
    .addr(eaddr), .syn(esyn), .err_in(err_in)
  );

  // ==========================================================
  // clock, flag counters, hang guard
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (corrected_read_flag === 1'b1) crd_cnt++;
    if (read_data_substitute_flag === 1'b1) rds_cnt++;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end

  // ==========================================================
  // tasks
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic guard(input int k);
    if (k >= 64) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // both channels offered together, each dropped on its own ready
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    @(posedge clk_sys);
    while ((s_axi_awvalid || s_axi_wvalid) && k < 64) begin
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      @(posedge clk_sys);
      k++;
    end
    while (s_axi_bvalid !== 1'b1 && k < 64) begin
      @(posedge clk_sys);
      k++;
    end
    s_axi_bready <= 1'b0;
    guard(k);
    chk("bresp", {30'h0, mcr_pkg::AXI_OKAY}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [3:0] a);
    int k;
    k = 0;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (s_axi_arready !== 1'b1 && k < 64);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1 && k < 64) begin
      @(posedge clk_sys);
      k++;
    end
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    guard(k);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [31:0] m, e);
    rd(a);
    chk(nm, e, rdat & m);
  endtask
  task automatic err(input logic c, input logic [19:0] a,
                     input logic [7:0] s);
    @(posedge clk_sys);
    fire  <= 1'b1;
    corr  <= c;
    eaddr <= a;
    esyn  <= s;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // power edges cross a synchroniser, so poll with a bound
  task automatic wait_alert(input logic e);
    int k;
    k = 0;
    while (power_alert_line !== e && k < 64) begin
      @(posedge clk_sys);
      k++;
    end
    guard(k);
    chk("power_alert_line", {31'h0, e}, {31'h0, power_alert_line});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk("init busy", 4'h4, 32'h0000_3000, 32'h0);
    array_cmd <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("array_busy", 32'h1, {31'h0, array_busy});
    init_active <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("array_busy idle", 32'h0, {31'h0, array_busy});
    init_done <= 1'b1;
    @(posedge clk_sys);
    init_done <= 1'b0;
    array_cmd <= 1'b0;
    rchk("reg_b cold", 4'h4, 32'hFFFF_BFFF, 32'h9040_3000);
    cold_start <= 1'b0;
    for (j = 0; j < 4; j++) begin
      mem_type <= j[1:0];
      mem_size <= 7'h7F ^ j[6:0];
      rchk("reg_a size type", 4'h0, 32'hFFFF_FFFE,
           {16'h0, 7'h7F ^ j[6:0], 4'h0, j[1:0], 3'h0});
    end
    wr(4'h0, 32'h0000_0001);
    rchk("ilv held", 4'h0, 32'h0000_01FF, 32'h0000_0018);
    wr(4'h0, 32'h0000_01E1);
    rchk("ilv set", 4'h0, 32'h0000_01FF, 32'h0000_0019);
    ac_low <= 1'b1;
    wait_alert(1'b1);
    rchk("power down", 4'h0, 32'h00C0_0000, 32'h0040_0000);
    wr(4'h0, 32'h0040_0000);
    wait_alert(1'b0);
    ac_low <= 1'b0;
    wait_alert(1'b1);
    rchk("power up", 4'h0, 32'h00C0_0000, 32'h0080_0000);
    wr(4'h0, 32'h0080_0000);
    wait_alert(1'b0);
    rchk("power clear", 4'h0, 32'h00C0_0001, 32'h0000_0001);
    rd_addr <= 32'h0000_1008;
    wr(4'h4, 32'h0200_02A5);
    rchk("sa held", 4'h4, 32'hFFFF_BFFF, 32'h9040_32A5);
    chk("force on", 32'h1, {31'h0, force_check_bits});
    chk("ecc_ctrl", 32'h1A5, {22'h0, ecc_ctrl});
    rd_addr <= 32'h0000_1000;
    repeat (2) @(posedge clk_sys);
    chk("force off", 32'h0, {31'h0, force_check_bits});
    wr(4'h4, 32'h0020_C100);
    rchk("sa new", 4'h4, 32'hFFFF_BFFF, 32'h9020_B100);
    chk("start_addr", 32'h41, {19'h0, start_addr});
    err(1'b1, 20'hABCDE, 8'h5A);
    rchk("log first", 4'h8, 32'hFFFF_FFFF, 32'h1ABC_DE5A);
    chk("crd bypass", 32'h0, crd_cnt);
    wr(4'h4, 32'h0000_0000);
    err(1'b1, 20'h12345, 8'h33);
    rchk("log second", 4'h8, 32'hFFFF_FFFF, 32'h3ABC_DE5A);
    chk("crd logged", 32'h0, crd_cnt);
    wr(4'h8, 32'h3000_0000);
    rchk("log serviced", 4'h8, 32'hF000_0000, 32'h0);
    err(1'b1, 20'h00F0F, 8'h81);
    chk("crd sent", 32'h1, crd_cnt);
    rchk("log again", 4'h8, 32'hFFFF_FFFF, 32'h100F_0F81);
    wr(4'h8, 32'h7000_0000);
    err(1'b1, 20'h00001, 8'h01);
    chk("crd inhibited", 32'h1, crd_cnt);
    err(1'b0, 20'h00002, 8'h02);
    chk("rds sent", 32'h1, rds_cnt);
    rchk("inhibit held", 4'h8, 32'hF000_0000, 32'h7000_0000);
    rd(4'hC);
    chk("unmapped data", 32'h0, rdat);
    chk("unmapped resp", 32'h2, {30'h0, rrsp});
    for (j = 0; j < 4; j++) begin
      {start_jumper_high, start_jumper_low} <= j[1:0];
      cold_start <= 1'b1;
      repeat (8) @(posedge clk_sys);
      cold_start <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("sa jumpers", {19'h0, sa_tab[j]}, {19'h0, start_addr});
      chk("ilv cold", 32'h0, {31'h0, interleave_bits});
    end
    init_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    init_active <= 1'b0;
    init_done <= 1'b1;
    @(posedge clk_sys);
    init_done <= 1'b0;
    rchk("init saved", 4'h4, 32'h0000_3000, 32'h0000_1000);
    report_and_stop();
  end
endmodule
`default_nettype wire
